// ---- imusp_port.sv ----
// Serial slave port with read budget, overrun flag, lock-up and flash write counter.
// Assumes pins arrive asynchronously, sclk well below a quarter of clk_sys_i,
// and that register read data is valid combinationally from reg_addr_o.
`timescale 1ns/1ps
`default_nettype none
`include "imusp_consts.svh"

module imusp_port #(
   parameter int DEC_W = 11
) (
   // System
   input  wire logic                  clk_sys_i,
   input  wire logic                  nrst_i,
   // Serial pins
   input  wire imusp_pkg::imusp_pins_s pins_i,
   output logic                       dout_o,
   // Device events and settings
   input  wire logic                  data_ready_i,
   input  wire logic                  flash_write_i,
   input  wire logic [DEC_W-1:0]      decimation_setting_i,
   input  wire logic                  diag_clear_i,
   // Register space
   output logic [6:0]                 reg_addr_o,
   output logic                       reg_rd_o,
   output logic                       reg_wr_o,
   output logic [7:0]                 reg_wdata_o,
   input  wire logic [15:0]           reg_rdata_i,
   // Status
   output logic                       overrun_flag_o,
   output logic                       port_locked_o
);

   // Pin synchroniser; q1 feeds only q2
   imusp_pkg::imusp_pins_s pins_q1, pins_q2, pins_q3;
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         pins_q1 <= `IMUSP_PINS_IDLE;
         pins_q2 <= `IMUSP_PINS_IDLE;
         pins_q3 <= `IMUSP_PINS_IDLE;
      end else begin
         pins_q1 <= pins_i;
         pins_q2 <= pins_q1;
         pins_q3 <= pins_q2;
      end
   end

   logic sclk_rise, sclk_fall, cs_act, cs_rise, cs_fall;
   always_comb begin
      cs_act    = !pins_q2.cs_n;
      sclk_rise = cs_act && pins_q2.sclk && !pins_q3.sclk;
      sclk_fall = cs_act && !pins_q2.sclk && pins_q3.sclk;
      cs_rise   = pins_q2.cs_n && !pins_q3.cs_n;
      cs_fall   = !pins_q2.cs_n && pins_q3.cs_n;
   end

   // Flash write counter, never written from the port
   logic [31:0] flash_cnt, next_flash_cnt;
   always_comb begin
      next_flash_cnt = flash_cnt;
      if (flash_write_i) begin
         next_flash_cnt = flash_cnt + 32'h0000_0001;
      end
   end
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         flash_cnt <= `IMUSP_CNT_RST;
      end else begin
         flash_cnt <= next_flash_cnt;
      end
   end

   // Serial engine
   imusp_pkg::imusp_state_e state, next_state;
   logic [4:0]  bit_cnt, next_bit_cnt;
   logic [5:0]  edge_tot, next_edge_tot;
   logic        seg_any, next_seg_any;
   logic [15:0] rx, next_rx;
   logic [15:0] tx, next_tx;
   logic [15:0] seg_len, next_seg_len;
   logic [6:0]  next_reg_addr;
   logic        next_reg_rd, next_reg_wr;
   logic [7:0]  next_reg_wdata;
   logic        next_dout;
   logic        seg_end, rd_ev;
   imusp_pkg::imusp_cmd_s cmd;

   always_comb begin
      next_state     = state;
      next_bit_cnt   = bit_cnt;
      next_edge_tot  = edge_tot;
      next_seg_any   = seg_any;
      next_rx        = rx;
      next_tx        = tx;
      next_seg_len   = seg_len;
      next_reg_addr  = reg_addr_o;
      next_reg_rd    = 1'b0;
      next_reg_wr    = 1'b0;
      next_reg_wdata = reg_wdata_o;
      cmd            = {rx[14:0], pins_q2.din};
      seg_end        = sclk_rise && (bit_cnt == `IMUSP_BIT_LAST);
      rd_ev          = seg_end && (state == imusp_pkg::PS_READY) && !cmd.wr;
      if (seg_len != `IMUSP_SEG_LEN_MAX) begin
         next_seg_len = seg_len + 16'h0001;
      end
      if (cs_fall || seg_end) begin
         next_seg_len = `IMUSP_WORD_RST;
      end
      if (sclk_rise) begin
         next_rx      = cmd;
         next_bit_cnt = bit_cnt + 5'h01;
         if (edge_tot != `IMUSP_EDGE_MAX) begin
            next_edge_tot = edge_tot + 6'h01;
         end
      end
      // Shift out on the falling edge after each sampled bit except the last bit of a segment
      if (sclk_fall && (bit_cnt != `IMUSP_BIT_ZERO)) begin
         next_tx = {tx[14:0], 1'b0};
      end
      if (seg_end) begin
         next_bit_cnt = `IMUSP_BIT_ZERO;
         next_seg_any = 1'b1;
         next_tx      = `IMUSP_WORD_RST;
         if (state == imusp_pkg::PS_READY) begin
            next_reg_addr = cmd.addr;
            if (cmd.wr) begin
               // Counter halves are read-only
               next_reg_wr    = (cmd.addr[6:2] != 5'(`IMUSP_ADDR_CNT_LOW >> 2));
               next_reg_wdata = cmd.data;
            end else begin
               next_reg_rd = 1'b1;
            end
         end
      end
      // Answer lands in the next segment; one 16-bit word per read
      if (reg_rd_o) begin
         if (reg_addr_o[6:1] == 6'(`IMUSP_ADDR_CNT_LOW >> 1)) begin
            next_tx = flash_cnt[15:0];
         end else if (reg_addr_o[6:1] == 6'(`IMUSP_ADDR_CNT_HIGH >> 1)) begin
            next_tx = flash_cnt[31:16];
         end else begin
            next_tx = reg_rdata_i;
         end
      end
      if (cs_rise) begin
         next_bit_cnt  = `IMUSP_BIT_ZERO;
         next_edge_tot = 6'h00;
         next_seg_any  = 1'b0;
         case (state)
            imusp_pkg::PS_READY: begin
               if (bit_cnt != `IMUSP_BIT_ZERO) begin
                  // Extra clocks are recoverable, a short frame is not
                  next_state = seg_any ? imusp_pkg::PS_OVERRUN
                                       : imusp_pkg::PS_LOCKED;
               end
            end
            imusp_pkg::PS_OVERRUN: begin
               if (edge_tot == `IMUSP_RECOVER_EDGES) begin
                  next_state = imusp_pkg::PS_READY;
               end
            end
            imusp_pkg::PS_LOCKED: begin
               next_state = imusp_pkg::PS_LOCKED;
            end
            default: begin
               next_state = imusp_pkg::PS_LOCKED;
            end
         endcase
      end
      next_dout = cs_act && (next_state == imusp_pkg::PS_READY) && next_tx[15];
   end

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         state         <= imusp_pkg::PS_READY;
         bit_cnt       <= `IMUSP_BIT_ZERO;
         edge_tot      <= 6'h00;
         seg_any       <= 1'b0;
         rx            <= `IMUSP_WORD_RST;
         tx            <= `IMUSP_WORD_RST;
         seg_len       <= `IMUSP_WORD_RST;
         reg_addr_o    <= 7'h00;
         reg_rd_o      <= 1'b0;
         reg_wr_o      <= 1'b0;
         reg_wdata_o   <= 8'h00;
         dout_o        <= 1'b0;
         port_locked_o <= 1'b0;
      end else begin
         state         <= next_state;
         bit_cnt       <= next_bit_cnt;
         edge_tot      <= next_edge_tot;
         seg_any       <= next_seg_any;
         rx            <= next_rx;
         tx            <= next_tx;
         seg_len       <= next_seg_len;
         reg_addr_o    <= next_reg_addr;
         reg_rd_o      <= next_reg_rd;
         reg_wr_o      <= next_reg_wr;
         reg_wdata_o   <= next_reg_wdata;
         dout_o        <= next_dout;
         port_locked_o <= (next_state == imusp_pkg::PS_LOCKED);
      end
   end

   // Read budget per data-ready interval
   logic [15:0] budget, rd_cnt, next_rd_cnt, rd_cost;
   logic        next_overrun;
   always_comb begin
      // Rate is setting plus one; budget grows with it
      budget = `IMUSP_READS_PER_DR * (16'(decimation_setting_i) + 16'h0001);
      // A slow segment eats two slots: the datapath keeps running meanwhile
      rd_cost = (seg_len > 16'(`IMUSP_SEG_SLOW_CYC)) ? `IMUSP_SLOW_COST
                                                    : `IMUSP_READ_COST;
      next_rd_cnt = rd_cnt;
      if (data_ready_i) begin
         next_rd_cnt = `IMUSP_WORD_RST;
      end
      if (rd_ev) begin
         next_rd_cnt = (data_ready_i ? `IMUSP_WORD_RST : rd_cnt) + rd_cost;
      end
      next_overrun = overrun_flag_o;
      if (diag_clear_i) begin
         next_overrun = 1'b0;
      end
      // Set beats clear
      if (rd_ev && (next_rd_cnt > budget)) begin
         next_overrun = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         rd_cnt         <= `IMUSP_WORD_RST;
         overrun_flag_o <= 1'b0;
      end else begin
         rd_cnt         <= next_rd_cnt;
         overrun_flag_o <= next_overrun;
      end
   end

   // Checks
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);

   property p_cnt_inc;
      flash_write_i |=> flash_cnt == $past(flash_cnt) + 32'h0000_0001;
   endproperty
   a_cnt_inc: assert property (p_cnt_inc) else $error("flash count did not step");

   property p_rd_high;
      reg_rd_o && (reg_addr_o == `IMUSP_ADDR_CNT_HIGH) |=> tx == $past(flash_cnt[31:16]);
   endproperty
   a_rd_high: assert property (p_rd_high) else $error("high count word wrong");

   property p_ro_write;
      reg_wr_o |-> reg_addr_o[6:2] != 5'h1F;
   endproperty
   a_ro_write: assert property (p_ro_write) else $error("write reached counter");

   property p_flag_cause;
      $rose(overrun_flag_o) |-> rd_cnt > $past(budget);
   endproperty
   a_flag_cause: assert property (p_flag_cause) else $error("overrun without excess");

   property p_flag_set;
      rd_ev && (next_rd_cnt > budget) |=> overrun_flag_o [*2];
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("overrun not held");

   // Clear only loses to a read that overruns in the same cycle
   property p_flag_clear;
      diag_clear_i && !rd_ev |=> !overrun_flag_o;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("overrun not cleared");

   property p_triple;
      decimation_setting_i == 11'h002 |-> budget == 16'h0024;
   endproperty
   a_triple: assert property (p_triple) else $error("budget not tripled");

   property p_slow;
      rd_ev && !data_ready_i && (seg_len > 16'(`IMUSP_SEG_SLOW_CYC))
         |=> rd_cnt == $past(rd_cnt) + 16'h0002;
   endproperty
   a_slow: assert property (p_slow) else $error("slow read not charged");

   property p_dr_clear;
      data_ready_i && !rd_ev |=> rd_cnt == 16'h0000;
   endproperty
   a_dr_clear: assert property (p_dr_clear) else $error("count not cleared");

   property p_short_lock;
      cs_rise && (state == imusp_pkg::PS_READY) && !seg_any && (bit_cnt != 5'h00)
         |=> port_locked_o ##1 port_locked_o;
   endproperty
   a_short_lock: assert property (p_short_lock) else $error("short frame not locked");

   property p_lock_quiet;
      port_locked_o |-> !reg_rd_o && !reg_wr_o && !dout_o;
   endproperty
   a_lock_quiet: assert property (p_lock_quiet) else $error("locked port answered");

endmodule // imusp_port
`default_nettype wire

// ---- imusp_consts.svh ----
// Constants of the serial port limiter and flash write counter.
// Assumes a single 10 MHz system clock; all times are converted to its cycles here.
// What this block does
// - Keep a 32-bit count of flash writes, split in two read-only 16-bit halves.
// - Low half reads at 0x7C/0x7D, high half at 0x7E/0x7F; not writable.
// - At decimation zero and full speed, twelve reads fit between data-ready pulses.
// - More reads than the budget in one interval flag a datapath overrun.
// - Read budget scales with decimation rate; setting 2 triples it.
// - Slower clocking or longer stalls use up the read budget faster.
// - Traffic runs in 16-bit segments; a broken count stops the port answering.
// - Too few clocks lock the port until the reset pin or power cycle.
// - Sensor words are 16 bits wide; each read returns one 16-bit word.
// - Decimation setting plus one gives the decimation rate.
`ifndef IMUSP_CONSTS_SVH
`define IMUSP_CONSTS_SVH

`define IMUSP_ADDR_CNT_LOW    7'h7C
`define IMUSP_ADDR_CNT_HIGH   7'h7E
`define IMUSP_BIT_LAST        5'h0F
`define IMUSP_BIT_ZERO        5'h00
`define IMUSP_RECOVER_EDGES   6'h11
`define IMUSP_EDGE_MAX        6'h3F
`define IMUSP_READS_PER_DR    16'h000C
`define IMUSP_READ_COST       16'h0001
`define IMUSP_SLOW_COST       16'h0002
`define IMUSP_CNT_RST         32'h0000_0000
`define IMUSP_WORD_RST        16'h0000
`define IMUSP_PINS_IDLE       3'h6
`define IMUSP_SEG_LEN_MAX     16'hFFFF

`define IMUSP_CLK_PERIOD_NS   100
// Shortest segment at top clock rate plus minimum stall
`define IMUSP_SEG_MIN_NS      17600
`define IMUSP_SEG_MIN_CYC     ((`IMUSP_SEG_MIN_NS + `IMUSP_CLK_PERIOD_NS - 1) / `IMUSP_CLK_PERIOD_NS)
// Longest segment that still earns the full budget: 10% above minimum, rounded down
`define IMUSP_SEG_SLOW_CYC    ((`IMUSP_SEG_MIN_NS * 11 / 10) / `IMUSP_CLK_PERIOD_NS)

`endif

// ---- imusp_pkg.sv ----
// Types shared by the serial port limiter.
// Assumes imusp_consts.svh supplies the numeric constants.
`default_nettype none
package imusp_pkg;

   typedef enum logic [2:0] {
      PS_READY   = 3'b001,
      PS_OVERRUN = 3'b010,
      PS_LOCKED  = 3'b100
   } imusp_state_e;

   typedef struct packed {
      logic sclk;
      logic cs_n;
      logic din;
   } imusp_pins_s;

   typedef struct packed {
      logic       wr;
      logic [6:0] addr;
      logic [7:0] data;
   } imusp_cmd_s;

endpackage
`default_nettype wire

// ---- imusp_host.sv ----
// Host-side serial master model that drives the port pins in mode 3.
// Assumes the bench calls its tasks; pins change 1 ns after clk_sys_i rises.
`timescale 1ns/1ps
`default_nettype none
module imusp_host (
   // System
   input  wire logic                   clk_sys_i,
   // Serial pins
   output var  imusp_pkg::imusp_pins_s pins_o,
   input  wire logic                   dout_i
);
   // Short half period keeps each segment near the minimum stall
   int half_cyc = 5;

   initial pins_o = 3'h6;

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask

   // One chip-select period with nrise sclk rises, MSB first
   task automatic frame(input int nrise, input logic [15:0] tx, output logic [15:0] rx);
      rx = 16'h0000;
      pins_o.cs_n = 1'b0;
      wait_clk(half_cyc);
      for (int i = 0; i < nrise; i++) begin
         pins_o.sclk = 1'b0;
         pins_o.din  = tx[15 - (i % 16)];
         wait_clk(half_cyc);
         rx = {rx[14:0], dout_i};
         pins_o.sclk = 1'b1;
         wait_clk(half_cyc);
      end
      pins_o.cs_n = 1'b1;
      // Released data line is not trusted to keep its last level
      pins_o.din  = ~pins_o.din;
      wait_clk(12);
   endtask

   // Overrun recovery: 17-rise frame, then a check read, bounded tries
   task automatic recover(input logic [15:0] cmd, input logic [15:0] want, output logic ok);
      logic [15:0] rx;
      ok = 1'b0;
      for (int t = 0; t < 15 && ok !== 1'b1; t++) begin
         frame(17, 16'hFFFF, rx);
         frame(16, cmd, rx);
         frame(16, cmd, rx);
         ok = (rx === want);
      end
   endtask
endmodule // imusp_host
`default_nettype wire

// ---- tb.sv ----
// Testbench: serial reads and writes, read budget, clock overrun and underrun.
// Assumes imusp_host drives the pins and the bench stands in for the register space.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic                   clk_sys_i = 1'b0;
   logic                   nrst_i    = 1'b0;
   imusp_pkg::imusp_pins_s pins;
   logic                   dout, rd_pulse, wr_pulse, ovr, lck, ok;
   logic                   flash_wr  = 1'b0;
   logic                   dr        = 1'b0;
   logic                   clr       = 1'b0;
   logic [10:0]            dec       = 11'h000;
   logic [6:0]             addr;
   logic [7:0]             wdata;
   logic [15:0]            rdata, d;
   logic [7:0]             wr_cnt    = 8'h00;
   logic [14:0]            wr_last   = 15'h0000;
   logic [7:0]             rd_seen   = 8'h00;
   logic [7:0]             rd_mark;
   int                     num_errors = 0;
   int                     n_tests    = 0;

   always #50 clk_sys_i = ~clk_sys_i;
   // Read data carries its own address so a wrong address shows up
   assign rdata = {9'h186, addr};

   always @(posedge clk_sys_i) begin
      if (wr_pulse === 1'b1) begin
         wr_cnt  <= wr_cnt + 8'h01;
         wr_last <= {addr, wdata};
      end
      if (rd_pulse === 1'b1) begin
         rd_seen <= rd_seen + 8'h01;
      end
   end

   imusp_port u_dut (
      .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .pins_i(pins), .dout_o(dout),
      .data_ready_i(dr), .flash_write_i(flash_wr), .decimation_setting_i(dec),
      .diag_clear_i(clr), .reg_addr_o(addr), .reg_rd_o(rd_pulse), .reg_wr_o(wr_pulse),
      .reg_wdata_o(wdata), .reg_rdata_i(rdata), .overrun_flag_o(ovr), .port_locked_o(lck)
   );

   imusp_host u_host (.clk_sys_i(clk_sys_i), .pins_o(pins), .dout_i(dout));

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic conclude();
      $display("checks %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Answer to a command arrives in the following segment
   task automatic rd(input logic [6:0] a, output logic [15:0] q);
      u_host.frame(16, {1'b0, a, 8'h00}, q);
      u_host.frame(16, 16'h0000, q);
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] v);
      logic [15:0] q;
      u_host.frame(16, {1'b1, a, v}, q);
   endtask

   // Fresh interval: n reads stay in budget, one more raises the flag
   task automatic budget(input logic [10:0] set, input int half, input int n);
      logic [15:0] q;
      dec = set;
      u_host.half_cyc = half;
      clr = 1'b1;
      cyc(1);
      clr = 1'b0;
      dr = 1'b1;
      cyc(1);
      dr = 1'b0;
      repeat (n) u_host.frame(16, 16'h1000, q);
      chk(16'(ovr), 16'h0000);
      u_host.frame(16, 16'h1000, q);
      chk(16'(ovr), 16'h0001);
   endtask

   initial begin
      repeat (100000) @(posedge clk_sys_i);
      num_errors++;
      $display("wrong value at %0t ns: run did not finish in time", $time);
      conclude();
   end

   initial begin
      cyc(8);
      nrst_i = 1'b1;
      cyc(4);
      chk(16'({ovr, lck, dout}), 16'h0000);
      repeat (3) begin
         flash_wr = 1'b1;
         cyc(1);
         flash_wr = 1'b0;
         cyc(1);
      end
      rd(7'h7C, d);
      chk(d, 16'h0003);
      chk(16'(rd_seen), 16'h0002);
      rd(7'h7D, d);
      chk(d, 16'h0003);
      rd(7'h7F, d);
      chk(d, 16'h0000);
      wr(7'h7C, 8'h55);
      wr(7'h21, 8'h5A);
      chk(16'(wr_cnt), 16'h0001);
      chk({1'b0, wr_last}, {1'b0, 7'h21, 8'h5A});
      rd(7'h7C, d);
      chk(d, 16'h0003);
      rd(7'h21, d);
      chk(d, 16'hC321);
      budget(11'h000, 5, 12);
      budget(11'h002, 5, 36);
      budget(11'h000, 8, 6);
      u_host.half_cyc = 5;
      // Too many clocks: port stops answering until a 17-rise frame
      u_host.frame(20, 16'h1000, d);
      rd(7'h10, d);
      chk(d, 16'h0000);
      u_host.recover({1'b0, 7'h7C, 8'h00}, 16'h0003, ok);
      chk(16'(ok), 16'h0001);
      // Too few clocks: only reset brings the port back
      u_host.frame(5, 16'h1000, d);
      chk(16'(lck), 16'h0001);
      rd_mark = rd_seen;
      u_host.recover({1'b0, 7'h10, 8'h00}, 16'hC310, ok);
      chk(16'(ok), 16'h0000);
      chk(16'(rd_seen - rd_mark), 16'h0000);
      nrst_i = 1'b0;
      cyc(8);
      nrst_i = 1'b1;
      cyc(4);
      chk(16'(lck), 16'h0000);
      rd(7'h10, d);
      chk(d, 16'hC310);
      conclude();
   end
endmodule // tb
`default_nettype wire
